// ### hw/imw_irq_map.sv
// Maps peripheral sources onto request lines, locates priority fields and gathers wake-ups.
// How it works
// - Each peripheral request number is its vector number minus sixteen.
// - The priority word for a request is the request number divided by four.
// - The field starts at eight times the request number modulo four, plus six.
// - Each priority field is two bits wide, giving four levels, other bits unused.
// - The converter completion drives request 15, vector 31, priority word 3.
// - The first comparator drives request 16, vector 32, priority word 4.
// - The second comparator drives request 21, vector 37, priority word 5.
// - All events of each flexible timer merge into requests 17, 18 and 19.
// - Any enabled keypad pin interrupt raises a wake-up out of Stop.
// - The converter on its internal clock runs in Stop and its completion wakes.
// - A serial peripheral interrupt in slave mode wakes the system from Stop.
// - An active edge on the serial receiver pin wakes the system from Stop.
// - The reset pin wakes from Stop only when clocked from the low-power oscillator.
`timescale 1ns/1ps
`include "imw_defs.svh"

module imw_irq_map
    import imw_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input imw_src_s src,
    input imw_wake_s wakeSrc,
    input wire logic [7:0] keyEnable,
    input wire logic stopEnter,
    input wire logic [5:0] queryVector,
    output logic [31:0] irqReq,
    output logic nmiReq,
    output logic wakeReq,
    output logic inStop,
    output logic [31:0] irqLevel,
    output imw_loc_s queryLoc,
    output logic queryValid
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops.
    logic rstSync1_ff;
    logic rstSync2_ff;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync1_ff <= 1'b0;
            rstSync2_ff <= 1'b0;
        end else begin
            rstSync1_ff <= 1'b1;
            rstSync2_ff <= rstSync1_ff;
        end
    end
    wire rstN = rstSync2_ff;

    ////////////////////////////////////////////////////////////////////////
    // Source to request mapping.
    function automatic logic anyBit(input logic [7:0] bits);
        anyBit = |bits;
    endfunction : anyBit

    logic [31:0] nxt_irqMap;
    always_comb begin
        nxt_irqMap = 32'h0;
        nxt_irqMap[`IMW_IRQ_FLASH] = src.flashCmd;
        nxt_irqMap[`IMW_IRQ_LVW] = src.lowVoltWarn;
        nxt_irqMap[`IMW_IRQ_EXTIRQ] = src.extIrq;
        nxt_irqMap[`IMW_IRQ_I2C] = src.i2cAny;
        nxt_irqMap[`IMW_IRQ_SPIA] = src.spiA;
        nxt_irqMap[`IMW_IRQ_SPIB] = src.spiB;
        nxt_irqMap[`IMW_IRQ_UARTA] = src.uartA;
        nxt_irqMap[`IMW_IRQ_UARTB] = src.uartB;
        nxt_irqMap[`IMW_IRQ_UARTC] = src.uartC;
        nxt_irqMap[`IMW_IRQ_CONV] = src.convDone;
        nxt_irqMap[`IMW_IRQ_CMPA] = src.cmpA;
        nxt_irqMap[`IMW_IRQ_TMRA] = anyBit(src.tmrA);
        nxt_irqMap[`IMW_IRQ_TMRB] = anyBit(src.tmrB);
        nxt_irqMap[`IMW_IRQ_TMRC] = anyBit(src.tmrC);
        nxt_irqMap[`IMW_IRQ_RTC] = src.rtcOvf;
        nxt_irqMap[`IMW_IRQ_CMPB] = src.cmpB;
        nxt_irqMap[`IMW_IRQ_PITA] = src.pitA;
        nxt_irqMap[`IMW_IRQ_PITB] = src.pitB;
        nxt_irqMap[`IMW_IRQ_KEYA] = anyBit(src.keyA & keyEnable);
        nxt_irqMap[`IMW_IRQ_KEYB] = anyBit(src.keyB);
        nxt_irqMap[`IMW_IRQ_CLKLOSS] = src.clkLoss;
        nxt_irqMap[`IMW_IRQ_WDOG] = src.wdogTimeout;
    end

    // Unassigned lines are forced low even if the map above changes.
    wire [31:0] irqMasked = nxt_irqMap & ~`IMW_UNUSED_MASK;

    logic [31:0] irqReq_ff;
    logic nmiReq_ff;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            irqReq_ff <= 32'h0;
            nmiReq_ff <= 1'b0;
        end else begin
            irqReq_ff <= irqMasked;
            nmiReq_ff <= wakeSrc.nmiPin & wakeSrc.nmiPinSel;
        end
    end
    assign irqReq = irqReq_ff;
    assign nmiReq = nmiReq_ff;

    ////////////////////////////////////////////////////////////////////////
    // One flag bit per request, set when its field position equals eight times its slot in the word plus six.
    genvar gi;
    generate
        for (gi = 0; gi < `IMW_NUM_IRQ; gi = gi + 1) begin : gLevel
            localparam int Lsb = `IMW_FIELD_STRIDE * (gi % 4) + `IMW_FIELD_OFFSET;
            assign irqLevel[gi] = (Lsb == 32'(`IMW_FIELD_STRIDE * (gi % 4) + 6));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Priority field locator for a queried vector.
    imw_loc_s locRaw;
    logic locPeripheral;
    imw_prio_locate uLocate (
        .vector(queryVector),
        .loc(locRaw),
        .isPeripheral(locPeripheral)
    );

    imw_loc_s queryLoc_ff;
    logic queryValid_ff;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            queryLoc_ff <= '0;
            queryValid_ff <= 1'b0;
        end else begin
            queryLoc_ff <= locRaw;
            queryValid_ff <= locPeripheral;
        end
    end
    assign queryLoc = queryLoc_ff;
    assign queryValid = queryValid_ff;

    ////////////////////////////////////////////////////////////////////////
    // Wake-up gathering; the result is combinational so it acts without a clock in Stop.
    wire keyWake = anyBit(src.keyA & keyEnable) | anyBit(src.keyB & keyEnable);
    wire convWake = wakeSrc.convDone & wakeSrc.convInternalClk;
    wire spiWake = wakeSrc.spiSlaveIrq & wakeSrc.spiSlaveMode;
    wire uartWake = wakeSrc.uartRxEdge;
    wire resetWake = wakeSrc.resetPin & wakeSrc.resetOnLowPowerOsc;
    wire nmiWake = wakeSrc.nmiPin & wakeSrc.nmiPinSel;
    wire anyWake = keyWake | convWake | spiWake | uartWake | resetWake | nmiWake
        | wakeSrc.lowVoltWarn | wakeSrc.extIrqPin | wakeSrc.cmpAny
        | wakeSrc.i2cAddrMatch | wakeSrc.rtcAlarm;

    imw_state_e state_ff;
    imw_state_e nxt_state;
    always_comb begin
        case (state_ff)
            IMW_RUN: nxt_state = stopEnter ? IMW_STOP : IMW_RUN;
            IMW_STOP: nxt_state = anyWake ? IMW_WAKE : IMW_STOP;
            IMW_WAKE: nxt_state = IMW_RUN;
            default: nxt_state = IMW_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_ff <= IMW_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign inStop = state_ff == IMW_STOP;
    assign wakeReq = inStop & anyWake;

endmodule : imw_irq_map

// ### hw/imw_defs.svh
// Constants for the interrupt map, priority field locator and wake-up gathering.
`ifndef IMW_DEFS_SVH
`define IMW_DEFS_SVH

`define IMW_VEC_BASE 6'h10
`define IMW_IRQ_W 5
`define IMW_VEC_W 6
`define IMW_NUM_IRQ 32
`define IMW_PRIO_FIELD_W 2
`define IMW_FIELD_STRIDE 8
`define IMW_FIELD_OFFSET 6
`define IMW_IRQ_FLASH 5'h05
`define IMW_IRQ_LVW 5'h06
`define IMW_IRQ_EXTIRQ 5'h07
`define IMW_IRQ_I2C 5'h08
`define IMW_IRQ_SPIA 5'h0a
`define IMW_IRQ_SPIB 5'h0b
`define IMW_IRQ_UARTA 5'h0c
`define IMW_IRQ_UARTB 5'h0d
`define IMW_IRQ_UARTC 5'h0e
`define IMW_IRQ_CONV 5'h0f
`define IMW_IRQ_CMPA 5'h10
`define IMW_IRQ_TMRA 5'h11
`define IMW_IRQ_TMRB 5'h12
`define IMW_IRQ_TMRC 5'h13
`define IMW_IRQ_RTC 5'h14
`define IMW_IRQ_CMPB 5'h15
`define IMW_IRQ_PITA 5'h16
`define IMW_IRQ_PITB 5'h17
`define IMW_IRQ_KEYA 5'h18
`define IMW_IRQ_KEYB 5'h19
`define IMW_IRQ_CLKLOSS 5'h1b
`define IMW_IRQ_WDOG 5'h1c
`define IMW_UNUSED_MASK 32'he400021f
`define IMW_TMR_SRC_W 8
`define IMW_KEY_PINS 8

`endif

// ### hw/imw_pkg.sv
// Types shared by the interrupt map and wake-up logic.
package imw_pkg;

    typedef struct packed {
        logic flashCmd;
        logic lowVoltWarn;
        logic extIrq;
        logic i2cAny;
        logic spiA;
        logic spiB;
        logic uartA;
        logic uartB;
        logic uartC;
        logic convDone;
        logic cmpA;
        logic [7:0] tmrA;
        logic [7:0] tmrB;
        logic [7:0] tmrC;
        logic rtcOvf;
        logic cmpB;
        logic pitA;
        logic pitB;
        logic [7:0] keyA;
        logic [7:0] keyB;
        logic clkLoss;
        logic wdogTimeout;
    } imw_src_s;

    typedef struct packed {
        logic resetPin;
        logic resetOnLowPowerOsc;
        logic lowVoltWarn;
        logic extIrqPin;
        logic convDone;
        logic convInternalClk;
        logic cmpAny;
        logic i2cAddrMatch;
        logic spiSlaveIrq;
        logic spiSlaveMode;
        logic uartRxEdge;
        logic rtcAlarm;
        logic nmiPin;
        logic nmiPinSel;
    } imw_wake_s;

    typedef struct packed {
        logic [4:0] irq;
        logic [2:0] wordIdx;
        logic [4:0] fieldLsb;
        logic [7:0] tableAddr;
    } imw_loc_s;

    typedef enum logic [2:0] {
        IMW_RUN = 3'b001,
        IMW_STOP = 3'b010,
        IMW_WAKE = 3'b100
    } imw_state_e;

endpackage : imw_pkg

// ### hw/imw_prio_locate.sv
// Locates a vector's request number, table address, priority word and field position.
`timescale 1ns/1ps
`include "imw_defs.svh"

module imw_prio_locate
    import imw_pkg::*;
(
    input wire logic [5:0] vector,
    output imw_loc_s loc,
    output logic isPeripheral
);
    wire [5:0] irqWide = vector - `IMW_VEC_BASE;
    wire [4:0] irqNum = irqWide[4:0];

    assign isPeripheral = vector >= `IMW_VEC_BASE;
    assign loc.irq = irqNum;
    assign loc.wordIdx = irqNum[4:2];
    assign loc.fieldLsb = {irqNum[1:0], 3'h6};
    assign loc.tableAddr = {vector, 2'h0};
endmodule : imw_prio_locate

// ### tb/imw_irq_map_assertions.sv
// Concurrent checks on the interrupt map ports.
`timescale 1ns/1ps
`include "imw_defs.svh"
module imw_irq_map_assertions
    import imw_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input imw_src_s src,
    input imw_wake_s wakeSrc,
    input wire logic [7:0] keyEnable,
    input wire logic [5:0] queryVector,
    input wire logic [31:0] irqReq,
    input wire logic nmiReq,
    input wire logic wakeReq,
    input wire logic inStop,
    input imw_loc_s queryLoc,
    input wire logic queryValid
);
    default clocking @(posedge clk); endclocking
    // Waits four edges after reset release, two more than the block's own, so that no check runs before its flip-flops have left reset.
    logic [3:0] rstSeen_ff;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSeen_ff <= 4'h0;
        end else begin
            rstSeen_ff <= {rstSeen_ff[2:0], 1'b1};
        end
    end
    default disable iff (!rstSeen_ff[3]);
    property p_unused; (irqReq & `IMW_UNUSED_MASK) == 32'h0; endproperty
    a_unused: assert property (p_unused) else $error("tied line set");
    property p_conv; irqReq[15] == $past(src.convDone); endproperty
    a_conv: assert property (p_conv) else $error("conv line");
    property p_cmp; irqReq[16] == $past(src.cmpA) && irqReq[21] == $past(src.cmpB); endproperty
    a_cmp: assert property (p_cmp) else $error("cmp lines");
    property p_tmr; irqReq[19:17] == {$past(|src.tmrC), $past(|src.tmrB), $past(|src.tmrA)}; endproperty
    a_tmr: assert property (p_tmr) else $error("timer lines");
    property p_irq; queryValid |-> {1'b0, queryLoc.irq} == $past(queryVector) - 6'h10; endproperty
    a_irq: assert property (p_irq) else $error("request number");
    property p_addr; queryLoc.tableAddr == {$past(queryVector), 2'b00}; endproperty
    a_addr: assert property (p_addr) else $error("table address");
    property p_fld; queryValid |-> queryLoc.wordIdx == queryLoc.irq[4:2] && queryLoc.fieldLsb == {queryLoc.irq[1:0], 3'b110};
    endproperty
    a_fld: assert property (p_fld) else $error("priority field");
    property p_wake; inStop && ((wakeSrc.resetPin && wakeSrc.resetOnLowPowerOsc) || wakeSrc.uartRxEdge
        || (wakeSrc.convDone && wakeSrc.convInternalClk) || (wakeSrc.spiSlaveIrq && wakeSrc.spiSlaveMode)
        || |({src.keyA, src.keyB} & {keyEnable, keyEnable})) |-> wakeReq; endproperty
    a_wake: assert property (p_wake) else $error("wake missed");
    property p_nmi; nmiReq == $past(wakeSrc.nmiPin && wakeSrc.nmiPinSel); endproperty
    a_nmi: assert property (p_nmi) else $error("nmi request");
endmodule : imw_irq_map_assertions
bind imw_irq_map imw_irq_map_assertions u_chk (.clk(clk), .arst_n(arst_n), .src(src), .wakeSrc(wakeSrc),
    .keyEnable(keyEnable), .queryVector(queryVector), .irqReq(irqReq), .nmiReq(nmiReq), .wakeReq(wakeReq),
    .inStop(inStop), .queryLoc(queryLoc), .queryValid(queryValid));

// ### tb/imw_core_model.sv
// Core side model: takes the pending request with the lowest number.
`timescale 1ns/1ps
module imw_core_model (
    input wire logic clk,
    input wire logic [31:0] irqReq,
    input wire logic nmiReq,
    output logic [5:0] takenVec
);
    always_ff @(posedge clk) begin
        takenVec <= 6'h00;
        for (int i = 31; i >= 0; i--) begin
            if (irqReq[i]) begin
                takenVec <= 6'(i + 16);
            end
        end
        if (nmiReq) begin
            takenVec <= 6'h02;
        end
    end
endmodule : imw_core_model

// ### tb/imw_irq_map_tb.sv
// Self-checking bench for the interrupt map and wake-up gathering.
`timescale 1ns/1ps
`include "imw_defs.svh"
module imw_irq_map_tb
    import imw_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    imw_src_s src = '0;
    imw_wake_s wakeSrc = '0;
    logic [7:0] keyEnable = 8'h00;
    logic stopEnter = 1'b0;
    logic [5:0] queryVector = 6'h00;
    logic [31:0] irqReq;
    logic [31:0] irqLevel;
    logic nmiReq, wakeReq, inStop, queryValid;
    imw_loc_s queryLoc;
    logic [5:0] takenVec;
    int err_total = 0;
    int samples_checked = 0;
    always #4 clk = ~clk;
    imw_irq_map DUT (.clk(clk), .arst_n(arst_n), .src(src), .wakeSrc(wakeSrc), .keyEnable(keyEnable),
        .stopEnter(stopEnter), .queryVector(queryVector), .irqReq(irqReq), .nmiReq(nmiReq), .wakeReq(wakeReq),
        .inStop(inStop), .irqLevel(irqLevel), .queryLoc(queryLoc), .queryValid(queryValid));
    imw_core_model CORE (.clk(clk), .irqReq(irqReq), .nmiReq(nmiReq), .takenVec(takenVec));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    // Raises one source bit of the packed source struct and checks the request lines.
    task automatic irq_one(input int srcBit, input int line);
        src = 57'h1 << srcBit;
        @(negedge clk);
        chk(irqReq, 32'h1 << line);
        src = '0;
        @(negedge clk);
    endtask : irq_one
    task automatic t_map;
        irq_one(47, 15);
        irq_one(46, 16);
        irq_one(20, 21);
        irq_one(45, 17);
        irq_one(30, 18);
        irq_one(25, 19);
        src.convDone = 1'b1;
        repeat (2) @(negedge clk);
        chk(32'(takenVec), 32'h1f);
        src = '1;
        keyEnable = 8'hff;
        @(negedge clk);
        chk(irqReq & `IMW_UNUSED_MASK, 32'h0);
        chk(irqReq, ~`IMW_UNUSED_MASK);
        src = '0;
        @(negedge clk);
    endtask : t_map
    task automatic t_loc;
        imw_loc_s e;
        queryVector = 6'h05;
        @(negedge clk);
        chk(32'(queryValid), 32'h0);
        chk(32'(queryLoc.tableAddr), 32'h14);
        chk(irqLevel, 32'hffffffff);
        for (int v = 16; v < 48; v++) begin
            queryVector = 6'(v);
            @(negedge clk);
            e = {5'(v - 16), 3'((v - 16) / 4), 5'(8 * ((v - 16) % 4) + 6), 8'(4 * v)};
            chk(32'(queryLoc), 32'(e));
            chk(32'(queryValid), 32'h1);
        end
    endtask : t_loc
    // Holds a wake source for a whole cycle; a refused one is replaced by the next call, a taken one is
    // cleared and Stop is entered again.
    task automatic wake_one(input logic [13:0] w, input logic [7:0] k, input logic e);
        wakeSrc = w;
        src.keyB = k;
        #1;
        chk(32'(wakeReq), 32'(e));
        @(negedge clk);
        chk(32'(inStop), 32'(!e));
        if (e) begin
            wakeSrc = '0;
            src.keyB = 8'h00;
            @(negedge clk);
            stopEnter = 1'b1;
            @(negedge clk);
            stopEnter = 1'b0;
            chk(32'(inStop), 32'h1);
        end
    endtask : wake_one
    task automatic t_wake;
        keyEnable = 8'h04;
        stopEnter = 1'b1;
        @(negedge clk);
        stopEnter = 1'b0;
        chk(32'(inStop), 32'h1);
        wake_one(14'h2000, 8'h00, 1'b0);
        wake_one(14'h3000, 8'h00, 1'b1);
        wake_one(14'h0200, 8'h00, 1'b0);
        wake_one(14'h0300, 8'h00, 1'b1);
        wake_one(14'h0020, 8'h00, 1'b0);
        wake_one(14'h0030, 8'h00, 1'b1);
        wake_one(14'h0000, 8'h08, 1'b0);
        wake_one(14'h0000, 8'h04, 1'b1);
        wake_one(14'h0008, 8'h00, 1'b1);
        wakeSrc = 14'h0002;
        repeat (3) @(negedge clk);
        chk(32'(nmiReq), 32'h0);
        wakeSrc = 14'h0003;
        @(negedge clk);
        chk(32'(nmiReq), 32'h1);
        @(negedge clk);
        chk(32'(takenVec), 32'h2);
    endtask : t_wake
    // Resets in mid-run with a source held high: lines stay low for two edges after release.
    task automatic t_reset;
        src.convDone = 1'b1;
        @(negedge clk);
        chk(irqReq, 32'h8000);
        arst_n = 1'b0;
        @(negedge clk);
        chk(irqReq, 32'h0);
        chk(32'(queryValid), 32'h0);
        arst_n = 1'b1;
        repeat (2) begin
            @(negedge clk);
            chk(irqReq, 32'h0);
        end
        @(negedge clk);
        chk(irqReq, 32'h8000);
        chk(32'(queryValid), 32'h1);
        src = '0;
    endtask : t_reset
    initial begin
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_map;
        t_loc;
        t_wake;
        t_reset;
        wrap_up;
    end
    initial begin
        #20000;
        err_total++;
        wrap_up;
    end
endmodule : imw_irq_map_tb
